// File: core/gich_pkg.sv
// shared constants and types of the bus interface command handler
package gich_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] REG_CFG = 5'h00;   // bus address setting
    localparam logic [4:0] REG_MASK = 5'h04;  // service request mask
    localparam logic [4:0] REG_STATE = 5'h08; // interface state, read only
    localparam logic [4:0] REG_STB = 5'h0C;   // status byte, read only
    localparam logic [4:0] REG_RXD = 5'h10;   // last received data byte
    localparam logic [4:0] REG_TXD = 5'h14;   // data byte for talking
    // reset values
    localparam logic [5:0] ADDR_RESET = 6'h03;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] TXD_RESET = 8'h00;
    // address setting limits
    localparam logic [5:0] ADDR_MAX = 6'h1E;       // 30, last addressable
    localparam logic [5:0] ADDR_TALK_ONLY = 6'h32; // 50, talk only
    // error codes cleared by device clear, bcd tenths
    localparam logic [7:0] ERR_CLR_FIRST = 8'h10;  // 1.0
    localparam logic [7:0] ERR_CLR_LAST = 8'h44;   // 4.4
    // status byte bit positions
    localparam int STB_READY = 0;
    localparam int STB_ERROR = 2;
    localparam int STB_FAIL = 3;
    localparam int STB_LOCAL = 4;
    localparam int STB_NOOSC = 5;
    localparam int STB_RQS = 6;
    // mask bits that may raise a service request
    localparam logic [7:0] SRQ_USED = 8'h3D;
    // positions in the synchronised pin vector
    localparam int PIN_ATN = 12;
    localparam int PIN_REN = 11;
    localparam int PIN_IFC = 10;
    localparam int PIN_EOI = 9;
    localparam int PIN_DAV = 8;
    localparam int PIN_W = 13;
    // interface command codes, seven bits, parity ignored
    localparam logic [6:0] C_NUL = 7'h00;
    localparam logic [6:0] C_GTL = 7'h01;
    localparam logic [6:0] C_SDC = 7'h04;
    localparam logic [6:0] C_GET = 7'h08;
    localparam logic [6:0] C_LLO = 7'h11;
    localparam logic [6:0] C_DCL = 7'h14;
    localparam logic [6:0] C_SPE = 7'h18;
    localparam logic [6:0] C_SPD = 7'h19;
    localparam logic [6:0] C_UNL = 7'h3F;
    localparam logic [6:0] C_UNT = 7'h5F;
    localparam logic [1:0] GRP_LAD = 2'h1; // bits 6:5 of listen address
    localparam logic [1:0] GRP_TAD = 2'h2; // bits 6:5 of talk address
    // decoded command kinds
    typedef enum logic [3:0] {
        CMD_NONE, CMD_NUL, CMD_GTL, CMD_SDC, CMD_GET, CMD_LLO, CMD_DCL,
        CMD_SPE, CMD_SPD, CMD_UNL, CMD_UNT, CMD_LAD, CMD_TAD
    } gich_cmd_t;
    // remote and local states
    typedef enum logic [1:0] {
        RL_LOCAL, RL_REMOTE, RL_LOCAL_LOCK, RL_REMOTE_LOCK
    } gich_rl_t;
endpackage

// File: core/gich_cmd_if.sv
// command byte and its decoded meaning between top and decoder
`timescale 1ns/10ps
interface gich_cmd_if;
    import gich_pkg::*;
    logic [7:0] cmd_byte; // byte on the data lines
    logic [4:0] my_addr;  // own primary address
    gich_cmd_t kind;      // decoded command
    logic match;          // address field equals own address
    modport dec (input cmd_byte, input my_addr, output kind, output match);
    modport user (output cmd_byte, output my_addr, input kind, input match);
endinterface

// File: core/gich_cmd_decoder.sv
// classifies an interface command byte
`timescale 1ns/10ps
module gich_cmd_decoder
    import gich_pkg::*;
(
    gich_cmd_if.dec cif
);
    // maps seven command bits onto a command kind
    function automatic gich_cmd_t classify(input logic [6:0] c);
        gich_cmd_t k;
        k = CMD_NONE;
        if (c == C_NUL) k = CMD_NUL;
        else if (c == C_GTL) k = CMD_GTL;
        else if (c == C_SDC) k = CMD_SDC;
        else if (c == C_GET) k = CMD_GET;
        else if (c == C_LLO) k = CMD_LLO;
        else if (c == C_DCL) k = CMD_DCL;
        else if (c == C_SPE) k = CMD_SPE;
        else if (c == C_SPD) k = CMD_SPD;
        else if (c == C_UNL) k = CMD_UNL;
        else if (c == C_UNT) k = CMD_UNT;
        else if (c[6:5] == GRP_LAD) k = CMD_LAD;
        else if (c[6:5] == GRP_TAD) k = CMD_TAD;
        return k;
    endfunction

    // decode of kind and address match
    always_comb begin
        cif.kind = classify(cif.cmd_byte[6:0]);
        cif.match = (cif.cmd_byte[4:0] == cif.my_addr);
    end
endmodule

// File: core/gich_top.sv
// device side interface command handler with avalon register slave
// Overview of operation
// - ATN true: data byte is a command
// - DCL aborts, flushes, resets, clears errors 1.0-4.4
// - listener, ATN false: EOI marks final byte
// - GET as listener: abort and restart measurement
// - GTL as listener: go local, keep lockout
// - IFC drops talker and listener, goes idle
// - matching listen address makes device listener
// - matching talk address makes device talker
// - LLO in remote disables the local key
// - REN false: local and lockout cleared
// - null command changes nothing
// - REN true enters remote state
// - SDC as listener acts like DCL
// - SPE enters serial poll, talk status byte
// - SPD leaves serial poll, talk data again
// - UNL drops listener addressing
// - UNT or other talk address drops talker
// - remote ignores panel keys; local key works only when not locked out
// - incoming service request ignored; raise enabled ones
// - status bits unmasked; only masked raise request
// - address 0-30 addressable, 50 talk only
`timescale 1ns/10ps
module gich_top
    import gich_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // bus pins, true means asserted
    input wire logic bus_atn,
    input wire logic bus_ren,
    input wire logic bus_ifc,
    input wire logic bus_eoi,
    input wire logic bus_dav,
    input wire logic [7:0] bus_dio_i,
    output logic [7:0] bus_dio_o,
    output logic bus_dio_oe,
    output logic bus_srq_o,
    output logic bus_srq_oe,
    // measurement core
    input wire logic cond_ready,
    input wire logic cond_error,
    input wire logic cond_fail,
    input wire logic cond_noosc,
    output logic trig_pulse,
    output logic clear_pulse,
    output logic [7:0] err_clr_first,
    output logic [7:0] err_clr_last,
    // front panel
    input wire logic [7:0] panel_keys,
    input wire logic panel_local_key,
    output logic [7:0] panel_keys_out,
    output logic remote_led,
    output logic talk_led,
    output logic listen_led,
    output logic srq_led
);
    // pin synchroniser stages, only pin_s2 reads pin_s1
    logic [PIN_W-1:0] pin_s1, pin_s2;
    logic dav_q; // delayed dav for edge detect
    // interface state
    gich_rl_t rl, next_rl; // remote/local state and its next value
    logic listener, talker; // addressed to listen, to talk
    logic spoll, ren_q; // serial poll mode, delayed remote enable
    // software registers
    logic [5:0] cfg_addr; // bus address setting
    logic [7:0] srq_mask, tx_data, rx_data; // mask, talk byte, heard byte
    logic rx_eoi, rx_valid; // heard byte ended a message, is unread
    // avalon handshake
    logic ack; // answer cycle of a request
    logic [31:0] rd_mux; // read data being selected
    // derived signals
    logic s_atn, s_ren, s_ifc, s_eoi, s_dav, dav_rise; // synced pins, new byte
    logic [7:0] s_dio, stb; // synced data lines, status byte
    logic talk_only, cmd_take, data_take; // mode, command or data taken
    logic remote, lockout, srq; // remote, lockout set, service wanted
    logic wr_go, rd_go; // write lands, read completes
    gich_cmd_if cif (); // decoder carrier
    // command byte decoder
    gich_cmd_decoder u_dec (
        .cif (cif.dec)
    );
    // true if an address selects a register word
    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        return a[4:2] == r[4:2];
    endfunction
    // two flops on every pin before any use
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            dav_q <= 1'b0;
            ren_q <= 1'b0;
        end else if (ce) begin
            pin_s1 <= {bus_atn, bus_ren, bus_ifc, bus_eoi, bus_dav,
                       bus_dio_i};
            pin_s2 <= pin_s1;
            dav_q <= pin_s2[PIN_DAV];
            ren_q <= pin_s2[PIN_REN];
        end
    end
    // pin names after synchronising
    assign s_atn = pin_s2[PIN_ATN];
    assign s_ren = pin_s2[PIN_REN];
    assign s_ifc = pin_s2[PIN_IFC];
    assign s_eoi = pin_s2[PIN_EOI];
    assign s_dav = pin_s2[PIN_DAV];
    assign s_dio = pin_s2[7:0];
    assign dav_rise = s_dav & ~dav_q;
    // decoder feed
    assign cif.cmd_byte = s_dio;
    assign cif.my_addr = cfg_addr[4:0];
    // talk only mode needs no controller, takes no commands
    assign talk_only = (cfg_addr == ADDR_TALK_ONLY);
    // attention makes the byte a command
    assign cmd_take = s_atn & dav_rise & ~talk_only;
    // data bytes only while listening with attention false
    assign data_take = ~s_atn & dav_rise & listener;
    assign remote = (rl == RL_REMOTE) | (rl == RL_REMOTE_LOCK);
    assign lockout = (rl == RL_LOCAL_LOCK) | (rl == RL_REMOTE_LOCK);
    // listener and talker addressing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            listener <= 1'b0;
            talker <= 1'b0;
        end else if (ce) begin
            if (talk_only) begin
                // output only, always talking
                listener <= 1'b0;
                talker <= 1'b1;
            end else if (s_ifc) begin
                // idle, no bus activity
                listener <= 1'b0;
                talker <= 1'b0;
            end else if (cmd_take) begin
                if (cif.kind == CMD_LAD && cif.match) begin
                    listener <= 1'b1;
                end else if (cif.kind == CMD_UNL) begin
                    listener <= 1'b0;
                end
                if (cif.kind == CMD_TAD) begin
                    // own address talks, any other untalks
                    talker <= cif.match;
                end else if (cif.kind == CMD_UNT) begin
                    talker <= 1'b0;
                end
            end
        end
    end
    // serial poll mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            spoll <= 1'b0;
        end else if (ce) begin
            if (s_ifc || talk_only) begin
                spoll <= 1'b0;
            end else if (cmd_take && cif.kind == CMD_SPE) begin
                spoll <= 1'b1;
            end else if (cmd_take && cif.kind == CMD_SPD) begin
                spoll <= 1'b0;
            end
        end
    end
    // remote/local transitions; null and unknown commands do nothing
    always_comb begin
        next_rl = rl;
        if (!s_ren || talk_only) begin
            // remote enable gone: local, lockout cleared
            next_rl = RL_LOCAL;
        end else begin
            unique case (rl)
                RL_LOCAL: begin
                    // entering remote on remote enable
                    if (s_ren && !ren_q) next_rl = RL_REMOTE;
                end
                RL_LOCAL_LOCK: begin
                    if (s_ren && !ren_q) next_rl = RL_REMOTE_LOCK;
                end
                RL_REMOTE: begin
                    if (cmd_take && cif.kind == CMD_GTL && listener) begin
                        next_rl = RL_LOCAL;
                    end else if (cmd_take && cif.kind == CMD_LLO) begin
                        next_rl = RL_REMOTE_LOCK;
                    end else if (panel_local_key) begin
                        // local key works while not locked out
                        next_rl = RL_LOCAL;
                    end
                end
                RL_REMOTE_LOCK: begin
                    // local key disabled; go to local keeps lockout
                    if (cmd_take && cif.kind == CMD_GTL && listener) begin
                        next_rl = RL_LOCAL_LOCK;
                    end
                end
            endcase
        end
    end
    // remote/local state register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rl <= RL_LOCAL;
        end else if (ce) begin
            rl <= next_rl;
        end
    end
    // one cycle trigger and clear toward the measurement core
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            trig_pulse <= 1'b0;
            clear_pulse <= 1'b0;
        end else if (ce) begin
            // abort and restart measurement on group trigger
            trig_pulse <= cmd_take & (cif.kind == CMD_GET)
                          & listener;
            // abort, flush sends, reset gate, blank, clear low errors
            clear_pulse <= cmd_take & ((cif.kind == CMD_DCL)
                           | ((cif.kind == CMD_SDC) & listener));
        end else begin
            trig_pulse <= 1'b0;
            clear_pulse <= 1'b0;
        end
    end
    // range of error codes a clear pulse removes
    assign err_clr_first = ERR_CLR_FIRST;
    assign err_clr_last = ERR_CLR_LAST;

    // status byte shows conditions regardless of the mask
    always_comb begin
        stb = 8'h00;
        stb[STB_READY] = cond_ready;
        stb[STB_ERROR] = cond_error;
        stb[STB_FAIL] = cond_fail;
        stb[STB_LOCAL] = ~remote;
        stb[STB_NOOSC] = cond_noosc;
        stb[STB_RQS] = srq;
    end
    // only masked-in conditions request service
    assign srq = |({2'b00, cond_noosc, ~remote, cond_fail, cond_error,
                    1'b0, cond_ready} & srq_mask & SRQ_USED);
    // bus outputs: request line and talker data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_srq_o <= 1'b0;
            bus_srq_oe <= 1'b0;
            bus_dio_o <= 8'h00;
            bus_dio_oe <= 1'b0;
        end else if (ce) begin
            // open drain request, pulled while condition stands
            bus_srq_o <= 1'b0;
            bus_srq_oe <= srq & ~talk_only;
            // status byte in serial poll, data otherwise
            bus_dio_o <= spoll ? stb : tx_data;
            bus_dio_oe <= talker & ~s_atn & ~s_ifc;
        end
    end
    // panel keys blocked in remote; local key handled above
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            panel_keys_out <= 8'h00;
        end else if (ce) begin
            panel_keys_out <= remote ? 8'h00 : panel_keys;
        end
    end
    // front panel status lamps
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            remote_led <= 1'b0;
            talk_led <= 1'b0;
            listen_led <= 1'b0;
            srq_led <= 1'b0;
        end else if (ce) begin
            remote_led <= remote;
            talk_led <= talker;
            listen_led <= listener;
            srq_led <= srq;
        end
    end
    // received data byte with end mark; new byte beats read clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_data <= 8'h00;
            rx_eoi <= 1'b0;
            rx_valid <= 1'b0;
        end else if (ce) begin
            if (data_take) begin
                rx_data <= s_dio;
                rx_eoi <= s_eoi;
                rx_valid <= 1'b1;
            end else if (rd_go && hit(avs_address, REG_RXD)) begin
                rx_valid <= 1'b0;
            end
        end
    end
    // avalon: one wait cycle, then the answer cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else if (ce) begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_go = avs_write & ack & ce;
    assign rd_go = avs_read & ack & ce;
    // writable registers, low byte lane only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_addr <= ADDR_RESET;
            srq_mask <= MASK_RESET;
            tx_data <= TXD_RESET;
        end else if (wr_go && avs_byteenable[0]) begin
            if (hit(avs_address, REG_CFG)) begin
                // only 0..30 and 50 are legal settings
                if (avs_writedata[5:0] <= ADDR_MAX ||
                    avs_writedata[5:0] == ADDR_TALK_ONLY) begin
                    cfg_addr <= avs_writedata[5:0];
                end
            end
            if (hit(avs_address, REG_MASK)) srq_mask <= avs_writedata[7:0];
            if (hit(avs_address, REG_TXD)) tx_data <= avs_writedata[7:0];
        end
    end
    // read multiplexer; unmapped words read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(avs_address, REG_CFG)) begin
            rd_mux[5:0] = cfg_addr;
        end else if (hit(avs_address, REG_MASK)) begin
            rd_mux[7:0] = srq_mask;
        end else if (hit(avs_address, REG_STATE)) begin
            rd_mux[6:0] = {talk_only, srq, spoll, talker, listener,
                           lockout, remote};
        end else if (hit(avs_address, REG_STB)) begin
            rd_mux[7:0] = stb;
        end else if (hit(avs_address, REG_RXD)) begin
            rd_mux[9:0] = {rx_valid, rx_eoi, rx_data};
        end else if (hit(avs_address, REG_TXD)) begin
            rd_mux[7:0] = tx_data;
        end
    end
    // read data captured in the wait cycle, stands in the answer cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ce && avs_read && !ack) begin
            avs_readdata <= rd_mux;
        end
    end
endmodule

// File: dv/gich_properties.sv
// assertions on the command handler top ports
`timescale 1ns/10ps
module gich_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic bus_atn,
    input wire logic bus_ren,
    input wire logic bus_ifc,
    input wire logic bus_dio_oe,
    input wire logic bus_srq_o,
    input wire logic trig_pulse,
    input wire logic clear_pulse,
    input wire logic [7:0] err_clr_first,
    input wire logic [7:0] err_clr_last,
    input wire logic [7:0] panel_keys_out,
    input wire logic remote_led,
    input wire logic listen_led
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // trigger is a single cycle pulse
    property p_trig_one;
        trig_pulse |=> !trig_pulse;
    endproperty
    a_trig_one: assert property (p_trig_one) else $error("trig");
    // clear is a single cycle pulse
    property p_clr_one;
        clear_pulse |=> !clear_pulse;
    endproperty
    a_clr_one: assert property (p_clr_one) else $error("clear long");
    // cleared error span is fixed
    property p_err_span;
        err_clr_first == 8'h10 && err_clr_last == 8'h44;
    endproperty
    a_err_span: assert property (p_err_span) else $error("err span");
    // open drain request never drives high
    property p_srq_pull;
        !bus_srq_o;
    endproperty
    a_srq_pull: assert property (p_srq_pull) else $error("srq high");
    // interface clear drops listening
    property p_ifc_unl;
        bus_ifc [*5] |=> !listen_led;
    endproperty
    a_ifc_unl: assert property (p_ifc_unl) else $error("ifc listen");
    // attention keeps the data lines free
    property p_atn_quiet;
        bus_atn [*4] |=> !bus_dio_oe;
    endproperty
    a_atn_quiet: assert property (p_atn_quiet) else $error("atn oe");
    // remote enable low returns local
    property p_ren_local;
        !bus_ren [*6] |=> !remote_led;
    endproperty
    a_ren_local: assert property (p_ren_local) else $error("ren");
    // panel keys blocked in remote
    property p_keys_off;
        remote_led && $past(remote_led) |-> panel_keys_out == 8'h00;
    endproperty
    a_keys_off: assert property (p_keys_off) else $error("keys");
    // one wait cycle then the answer
    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait");
endmodule
bind gich_top gich_props u_props (.ref_clk, .rst_n, .avs_read, .avs_write,
    .avs_waitrequest, .bus_atn, .bus_ren, .bus_ifc, .bus_dio_oe, .bus_srq_o,
    .trig_pulse, .clear_pulse, .err_clr_first, .err_clr_last,
    .panel_keys_out, .remote_led, .listen_led);

// File: dv/gich_ctl_model.sv
// bus controller model that sends interface commands
`timescale 1ns/10ps
module gich_ctl_model
    import gich_pkg::*;
#(
    parameter logic [4:0] CTL_ADDR = 5'h1E // controller's own address
)(
    input wire logic clk,
    output logic atn,
    output logic ren,
    output logic ifc,
    output logic eoi,
    output logic dav,
    output logic [7:0] dio,
    input wire logic [7:0] dio_in,
    input wire logic dio_oe
);
    // lines start released, read as false
    initial {atn, ren, ifc, eoi, dav, dio} = 13'h0000;
    // one byte per strobe, held past the sync delay
    task automatic send(input logic a, input logic [7:0] b, input logic e);
        @(posedge clk);
        {atn, eoi, dio} <= {a, e, b};
        repeat (3) @(posedge clk);
        dav <= 1'b1;
        repeat (4) @(posedge clk);
        {atn, eoi, dav, dio} <= 11'h000; // released lines fall false
        repeat (4) @(posedge clk);
    endtask
    // remote enable level change
    task automatic set_ren(input logic v);
        @(posedge clk);
        ren <= v;
        repeat (6) @(posedge clk);
    endtask
    // interface clear pulse
    task automatic pulse_ifc;
        @(posedge clk);
        ifc <= 1'b1;
        repeat (5) @(posedge clk);
        ifc <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // clear one device
    task automatic clear_dev(input logic [4:0] a);
        send(1'b1, {1'b0, C_UNL}, 1'b0);
        send(1'b1, {1'b0, GRP_TAD, CTL_ADDR}, 1'b0);
        send(1'b1, {1'b0, GRP_LAD, a}, 1'b0);
        send(1'b1, {1'b0, C_SDC}, 1'b0);
    endtask
    // status byte read with poll enable and disable
    task automatic poll(input logic [4:0] a, output logic [7:0] sb);
        send(1'b1, {1'b0, C_UNL}, 1'b0);
        send(1'b1, {1'b0, GRP_LAD, CTL_ADDR}, 1'b0);
        send(1'b1, {1'b0, GRP_TAD, a}, 1'b0);
        send(1'b1, {1'b0, C_SPE}, 1'b0);
        @(negedge clk);
        sb = dio_oe ? dio_in : 8'hxx;
        send(1'b1, {1'b0, C_SPD}, 1'b0);
        send(1'b1, {1'b0, C_UNT}, 1'b0);
    endtask
endmodule

// File: dv/testbench.sv
// self-checking bench for the command handler
`timescale 1ns/10ps
module testbench
    import gich_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF, cond = 4'h0;
    logic bus_atn, bus_ren, bus_ifc, bus_eoi, bus_dav, bus_dio_oe;
    logic [7:0] bus_dio_i, bus_dio_o, panel_keys = 8'h00, panel_keys_out;
    logic trig_pulse, clear_pulse, bus_srq_oe, panel_local_key = 1'b0;
    logic remote_led, talk_led, listen_led, srq_led;
    logic [7:0] sb, sbx;
    logic [31:0] exp_q[$];
    logic [1:0] ev_q[$];
    int err_count = 0, tests_run = 0, cyc = 0;
    gich_top uut (.ref_clk, .rst_n, .ce, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .bus_atn, .bus_ren, .bus_ifc, .bus_eoi, .bus_dav,
        .bus_dio_i, .bus_dio_o, .bus_dio_oe, .bus_srq_o(), .bus_srq_oe,
        .cond_ready(cond[0]), .cond_error(cond[1]), .cond_fail(cond[2]),
        .cond_noosc(cond[3]), .trig_pulse, .clear_pulse, .err_clr_first(),
        .err_clr_last(), .panel_keys, .panel_local_key, .panel_keys_out,
        .remote_led, .talk_led, .listen_led, .srq_led);
    gich_ctl_model u_ctl (.clk(ref_clk), .atn(bus_atn), .ren(bus_ren),
        .ifc(bus_ifc), .eoi(bus_eoi), .dav(bus_dav), .dio(bus_dio_i),
        .dio_in(bus_dio_o), .dio_oe(bus_dio_oe));
    initial forever #2.5 ref_clk = ~ref_clk;
    // compare seen against expected, count both
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    // answers are matched to the oldest note
    always @(negedge ref_clk) begin
        if (avs_read && avs_waitrequest === 1'b0)
            chk("readdata", avs_readdata, exp_q.pop_front());
        if (trig_pulse || clear_pulse)
            chk("pulse", 32'({trig_pulse, clear_pulse}), 32'(ev_q.pop_front()));
    end
    // one slave access, held until waitrequest is low
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        @(posedge ref_clk);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        {avs_write, avs_read} <= 2'b00;
    endtask
    task automatic rd(logic [4:0] a, logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // command byte with random ignored top bit
    task automatic cmd(logic [6:0] c);
        u_ctl.send(1'b1, {1'($urandom), c}, 1'b0);
    endtask
    initial begin
        void'($urandom(32'h2beb_2b1a));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(REG_CFG, 32'h0000_0003);
        rd(REG_MASK, 32'h0000_0000);
        rd(5'h18, 32'h0000_0000);
        bus(1'b1, REG_TXD, 32'h0000_00A5);
        panel_keys <= 8'($urandom);
        u_ctl.set_ren(1'b1);
        cmd({GRP_LAD, 5'h03});
        rd(REG_STATE, 32'h0000_0005);
        chk("leds", 32'({remote_led, talk_led, listen_led}), 32'h5);
        cmd(C_NUL);
        rd(REG_STATE, 32'h0000_0005);
        cmd(C_LLO);
        rd(REG_STATE, 32'h0000_0007);
        cmd(C_GTL);
        rd(REG_STATE, 32'h0000_0006);
        chk("keys", 32'(panel_keys_out), 32'(panel_keys));
        ev_q.push_back(2'b10);
        cmd(C_GET);
        ev_q.push_back(2'b01);
        cmd(C_DCL);
        ev_q.push_back(2'b01);
        cmd(C_SDC);
        cmd(C_UNL);
        rd(REG_STATE, 32'h0000_0002);
        cmd(C_GET);
        cmd(C_SDC);
        cond <= 4'($urandom);
        cmd({GRP_TAD, 5'h03});
        rd(REG_STATE, 32'h0000_000A);
        cmd(C_SPE);
        rd(REG_STATE, 32'h0000_001A);
        sbx = {2'b00, cond[3], 1'b1, cond[2], cond[1], 1'b0, cond[0]};
        chk("status", 32'(bus_dio_o), 32'(sbx));
        rd(REG_STB, 32'(sbx));
        cmd(C_SPD);
        chk("data", 32'({bus_dio_oe, bus_dio_o}), 32'h0000_01A5);
        cmd({GRP_TAD, 5'h04});
        rd(REG_STATE, 32'h0000_0002);
        cmd({GRP_TAD, 5'h03});
        cmd(C_UNT);
        rd(REG_STATE, 32'h0000_0002);
        u_ctl.set_ren(1'b0);
        rd(REG_STATE, 32'h0000_0000);
        u_ctl.set_ren(1'b1);
        panel_local_key <= 1'b1;
        repeat (6) @(posedge ref_clk);
        panel_local_key <= 1'b0;
        rd(REG_STATE, 32'h0000_0000);
        ev_q.push_back(2'b01);
        u_ctl.clear_dev(5'h03);
        rd(REG_STATE, 32'h0000_0004);
        u_ctl.pulse_ifc();
        rd(REG_STATE, 32'h0000_0000);
        cmd({GRP_LAD, 5'h03});
        u_ctl.send(1'b0, 8'h5A, 1'b1);
        rd(REG_RXD, 32'h0000_035A);
        cmd(C_UNL);
        bus(1'b1, REG_CFG, 32'h0000_001F);
        rd(REG_CFG, 32'h0000_0003);
        bus(1'b1, REG_CFG, 32'h0000_0032);
        rd(REG_STATE, 32'h0000_0048);
        bus(1'b1, REG_CFG, 32'h0000_0003);
        u_ctl.pulse_ifc();
        cond <= 4'h1;
        rd(REG_STB, 32'h0000_0011);
        bus(1'b1, REG_MASK, 32'h0000_0001);
        rd(REG_STB, 32'h0000_0051);
        rd(REG_STATE, 32'h0000_0020);
        chk("srq", 32'({srq_led, bus_srq_oe}), 32'h3);
        u_ctl.poll(5'h03, sb);
        chk("poll", 32'(sb), 32'h0000_0051);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(REG_MASK, 32'h0000_0000);
        chk("pulses left", 32'(ev_q.size()), 32'h0000_0000);
        wrap_up();
    end
endmodule
